// ---- smsf_pkg.sv ----
package smsf_pkg;
    // data path and fifo shape
    localparam int WORD_W = 16;
    localparam int FIFO_DEPTH = 32;
    localparam int NUM_TARGETS = 4;
    localparam int LEN_W = 4;
    localparam int DIV_W = 8;

    // frame length is coded as bit count minus one
    localparam logic [LEN_W-1:0] LEN_MIN = 4'h3;
    localparam logic [LEN_W-1:0] LEN_MAX = 4'hF;

    // per-target frame format select
    localparam logic FMT_SPI = 1'b0;
    localparam logic FMT_FRAME = 1'b1;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SYNC,
        ST_SHIFT,
        ST_GAP
    } smsf_state_t;

    // codes below four bits are raised to four bits
    function automatic logic [LEN_W-1:0] smsf_len(input logic [LEN_W-1:0] raw);
        return (raw < LEN_MIN) ? LEN_MIN : raw;
    endfunction

    // left-align a word so its frame msb sits in the top bit
    function automatic logic [WORD_W-1:0] smsf_align(input logic [WORD_W-1:0] w,
                                                     input logic [LEN_W-1:0] len);
        return w << (LEN_MAX - len);
    endfunction
endpackage

// ---- smsf_fifo.sv ----
`timescale 1ns/1ps
module smsf_fifo #(
    parameter int WIDTH = smsf_pkg::WORD_W,
    parameter int DEPTH = smsf_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic push,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic pop,
    output logic [WIDTH-1:0] rdata,
    output logic full,
    output logic empty,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic do_push;
    logic do_pop;

    // a push into a full fifo or a pop from an empty one is dropped
    assign do_push = push & ~full;
    assign do_pop = pop & ~empty;
    assign full = (cnt_q == CNT_FULL);
    assign empty = (cnt_q == '0);
    assign level = cnt_q;
    assign rdata = mem_q[rd_q];

    // pointers wrap naturally, so depth must be a power of two
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (do_push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (do_pop) begin
                rd_q <= rd_q + 1'b1;
            end
            case ({do_push, do_pop})
                2'b10: cnt_q <= cnt_q + 1'b1;
                2'b01: cnt_q <= cnt_q - 1'b1;
                default: cnt_q <= cnt_q;
            endcase
        end
    end

    // storage needs no reset, only the pointers and the count do
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem_q[wr_q] <= wdata;
        end
    end
endmodule

// ---- smsf_top.sv ----
`timescale 1ns/1ps
// Behaviour
// - master or slave; sequences up to four targets
// - separate 16 by 32 transmit and receive fifos
// - classic spi or frame-pulse format selectable
// - frame length programmable from 4 to 16
// - msb first out and in
// - separate masks for tx, rx, overrun sources
// - one combined irq from unmasked active sources
// - master serial clock at most half branch rate
// - internal loopback of sent data to receiver
// - serial clock via prescaler then rate divider
// - clock polarity, format, length taken per target
// - selects: high sync pulse or low chip select
// - select and clock driven only as master
// - slave honours only select line zero
// - data leaves on out pin, enters on in
// - start by software or timer trigger
// - registers on bus clock, divider on branch tick
module smsf_top #(
    parameter int TARGETS = smsf_pkg::NUM_TARGETS,
    parameter int DIV_W = smsf_pkg::DIV_W,
    parameter int DEPTH = smsf_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic master_mode,
    input wire logic loopback,
    input wire logic serial_branch_clock,
    input wire logic [DIV_W-1:0] prescale,
    input wire logic [DIV_W-1:0] bit_rate_div,
    input wire logic [$clog2(TARGETS)-1:0] seq_last,
    input wire logic [TARGETS*smsf_pkg::LEN_W-1:0] per_target_config_len,
    input wire logic [TARGETS-1:0] per_target_config_fmt,
    input wire logic [TARGETS-1:0] per_target_config_pol,
    input wire logic sw_start,
    input wire logic timer_trigger,
    input wire logic timer_trig_en,
    input wire logic tx_push,
    input wire logic [smsf_pkg::WORD_W-1:0] tx_data,
    input wire logic rx_pop,
    input wire logic mask_tx,
    input wire logic mask_rx,
    input wire logic mask_ovr,
    input wire logic overrun_clear,
    input wire logic serial_clock_pin_in,
    input wire logic slave_select_zero_in,
    input wire logic serial_data_in_pin,
    output logic tx_full,
    output logic rx_empty,
    output logic [smsf_pkg::WORD_W-1:0] rx_data,
    output logic overrun_q,
    output logic busy_q,
    output logic combined_irq_out,
    output logic serial_clock_pin_out,
    output logic serial_clock_pin_oe_n,
    output logic [TARGETS-1:0] slave_select_line_out,
    output logic slave_select_line_oe_n,
    output logic serial_data_out_pin
);
    localparam int TGT_W = $clog2(TARGETS);
    localparam int LVL_W = $clog2(DEPTH) + 1;
    localparam int WW = smsf_pkg::WORD_W;
    localparam int LW = smsf_pkg::LEN_W;
    localparam logic [LVL_W-1:0] LVL_HALF = LVL_W'(DEPTH / 2);

    smsf_pkg::smsf_state_t state_q;
    logic [TGT_W-1:0] tgt_q;
    logic phase_q;
    logic [LW-1:0] bitcnt_q;
    logic [WW-1:0] shreg_q;
    logic [WW-1:0] rxsh_q;
    logic [DIV_W-1:0] pre_cnt_q;
    logic [DIV_W-1:0] rate_cnt_q;
    logic half_tick_q;
    logic start_pend_q;
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic slv_clk_prev_q;
    logic slv_sel_prev_q;
    logic slv_active_q;
    logic slv_pend_q;
    logic rx_push_q;
    logic [WW-1:0] rx_word_q;
    logic irq_q;
    logic sclk_q;
    logic sclk_oe_n_q;
    logic [TARGETS-1:0] sel_q;
    logic sel_oe_n_q;

    logic mst_on;
    logic slv_on;
    logic tx_empty;
    logic rx_full;
    logic [WW-1:0] tx_word;
    logic [LVL_W-1:0] tx_level;
    logic [LVL_W-1:0] rx_level;
    logic [LW-1:0] cur_len;
    logic [LW-1:0] slv_len;
    logic [LW-1:0] load_len;
    logic [TGT_W-1:0] load_tgt;
    logic load_go;
    logic more;
    logic mst_done;
    logic din;
    logic sclk_s;
    logic sel_s;
    logic sdi_s;
    logic slv_clk;
    logic slv_sample_edge;
    logic slv_shift_edge;
    logic slv_arm;
    logic slv_sample;
    logic slv_last;
    logic slv_load;
    logic tx_pop;
    logic [TARGETS-1:0] sel_idle;

    // per-target length lookup, shared by load and shift control
    function automatic logic [LW-1:0] tgt_len(input logic [TGT_W-1:0] idx);
        return smsf_pkg::smsf_len(per_target_config_len[idx*LW +: LW]);
    endfunction

    assign mst_on = enable & master_mode;
    assign slv_on = enable & ~master_mode;
    assign cur_len = tgt_len(tgt_q);
    assign slv_len = tgt_len('0);
    assign more = (tgt_q != seq_last);
    // idle select level: high for chip select, low for frame sync
    assign sel_idle = ~per_target_config_fmt;

    // synchronised pin samples; only the second stage is used
    assign sclk_s = sync2_q[0];
    assign sel_s = sync2_q[1];
    assign sdi_s = sync2_q[2];
    // loopback feeds our own output bit back to the receiver
    assign din = loopback ? shreg_q[WW-1] : sdi_s;

    // master load of a word: first target from idle, next from gap
    always_comb begin
        load_go = 1'b0;
        load_tgt = '0;
        if (state_q == smsf_pkg::ST_IDLE) begin
            load_go = mst_on & start_pend_q & ~tx_empty;
        end else if (state_q == smsf_pkg::ST_GAP) begin
            load_tgt = tgt_q + 1'b1;
            load_go = mst_on & half_tick_q & more & ~tx_empty;
        end
    end

    assign mst_done = (state_q == smsf_pkg::ST_SHIFT) & half_tick_q & phase_q &
                      (bitcnt_q == cur_len);

    // slave edges; frame format samples on the opposite clock edge
    assign slv_clk = sclk_s ^ per_target_config_pol[0] ^ per_target_config_fmt[0];
    assign slv_sample_edge = slv_clk & ~slv_clk_prev_q;
    assign slv_shift_edge = ~slv_clk & slv_clk_prev_q;
    // only select zero starts a slave frame
    assign slv_arm = slv_on & (per_target_config_fmt[0] ? (slv_sample_edge & sel_s) :
                     (~sel_s & slv_sel_prev_q));
    assign slv_sample = slv_on & slv_active_q & slv_sample_edge & ~slv_arm;
    assign slv_last = slv_sample & (bitcnt_q == slv_len);
    // classic spi slave reloads for back-to-back words under one select
    assign slv_load = slv_arm | (slv_last & ~per_target_config_fmt[0]);
    assign load_len = mst_on ? tgt_len(load_tgt) : slv_len;
    assign tx_pop = (load_go | slv_load) & ~tx_empty;

    // transmit and receive buffers
    smsf_fifo #(
        .WIDTH(WW),
        .DEPTH(DEPTH)
    ) u_tx_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .push(tx_push),
        .wdata(tx_data),
        .pop(tx_pop),
        .rdata(tx_word),
        .full(tx_full),
        .empty(tx_empty),
        .level(tx_level)
    );

    smsf_fifo #(
        .WIDTH(WW),
        .DEPTH(DEPTH)
    ) u_rx_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .push(rx_push_q),
        .wdata(rx_word_q),
        .pop(rx_pop),
        .rdata(rx_data),
        .full(rx_full),
        .empty(rx_empty),
        .level(rx_level)
    );

    // two-stage synchronisers for clock, select zero and data in
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sync1_q <= 3'h2; // select idle high
            sync2_q <= 3'h2;
            slv_clk_prev_q <= 1'b0;
            slv_sel_prev_q <= 1'b1;
        end else begin
            sync1_q <= {serial_data_in_pin, slave_select_zero_in, serial_clock_pin_in};
            sync2_q <= sync1_q;
            // edge detection relies on a slow enough external clock
            slv_clk_prev_q <= slv_clk;
            slv_sel_prev_q <= sel_s;
        end
    end

    // prescaler then rate divider, stepped by the branch clock tick
    always_ff @(posedge clk) begin
        if (sys_rst || state_q == smsf_pkg::ST_IDLE) begin
            pre_cnt_q <= '0;
            rate_cnt_q <= '0;
            half_tick_q <= 1'b0;
        end else begin
            half_tick_q <= 1'b0;
            if (serial_branch_clock) begin
                if (pre_cnt_q == prescale) begin
                    pre_cnt_q <= '0;
                    if (rate_cnt_q == bit_rate_div) begin
                        rate_cnt_q <= '0;
                        half_tick_q <= 1'b1;
                    end else begin
                        rate_cnt_q <= rate_cnt_q + 1'b1;
                    end
                end else begin
                    pre_cnt_q <= pre_cnt_q + 1'b1;
                end
            end
        end
    end

    // pending start; a new trigger wins over the clear at start
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            start_pend_q <= 1'b0;
        end else if (sw_start || (timer_trig_en && timer_trigger)) begin
            start_pend_q <= 1'b1;
        end else if (load_go && state_q == smsf_pkg::ST_IDLE) begin
            start_pend_q <= 1'b0;
        end
    end

    // master sequencer over the targets
    always_ff @(posedge clk) begin
        if (sys_rst || !mst_on) begin
            state_q <= smsf_pkg::ST_IDLE;
            tgt_q <= '0;
            phase_q <= 1'b0;
        end else if (load_go) begin
            tgt_q <= load_tgt;
            phase_q <= 1'b0;
            if (per_target_config_fmt[load_tgt] == smsf_pkg::FMT_FRAME) begin
                state_q <= smsf_pkg::ST_SYNC;
            end else begin
                state_q <= smsf_pkg::ST_SHIFT;
            end
        end else if (half_tick_q) begin
            case (state_q)
                smsf_pkg::ST_SYNC: begin
                    phase_q <= ~phase_q;
                    if (phase_q) begin
                        state_q <= smsf_pkg::ST_SHIFT;
                    end
                end
                smsf_pkg::ST_SHIFT: begin
                    phase_q <= ~phase_q;
                    if (mst_done) begin
                        state_q <= smsf_pkg::ST_GAP;
                    end
                end
                smsf_pkg::ST_GAP: state_q <= smsf_pkg::ST_IDLE;
                default: state_q <= smsf_pkg::ST_IDLE;
            endcase
        end
    end

    // shift data path, shared by master and slave
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shreg_q <= '0;
            rxsh_q <= '0;
            bitcnt_q <= '0;
            slv_pend_q <= 1'b0;
        end else if (load_go || slv_load) begin
            // an empty tx fifo in slave mode sends zeros
            shreg_q <= tx_empty ? '0 : smsf_pkg::smsf_align(tx_word, load_len);
            rxsh_q <= '0;
            bitcnt_q <= '0;
            slv_pend_q <= 1'b0;
        end else if (mst_on && state_q == smsf_pkg::ST_SHIFT && half_tick_q) begin
            if (!phase_q) begin
                rxsh_q <= {rxsh_q[WW-2:0], din};
            end else if (bitcnt_q != cur_len) begin
                shreg_q <= {shreg_q[WW-2:0], 1'b0};
                bitcnt_q <= bitcnt_q + 1'b1;
            end
        end else if (slv_sample) begin
            rxsh_q <= {rxsh_q[WW-2:0], din};
            bitcnt_q <= bitcnt_q + 1'b1;
            slv_pend_q <= 1'b1;
        end else if (slv_shift_edge && slv_pend_q) begin
            shreg_q <= {shreg_q[WW-2:0], 1'b0};
            slv_pend_q <= 1'b0;
        end
    end

    // slave frame activity from select zero
    always_ff @(posedge clk) begin
        if (sys_rst || !slv_on) begin
            slv_active_q <= 1'b0;
        end else if (slv_arm) begin
            slv_active_q <= 1'b1;
        end else if (per_target_config_fmt[0] == smsf_pkg::FMT_SPI && sel_s) begin
            slv_active_q <= 1'b0;
        end else if (per_target_config_fmt[0] == smsf_pkg::FMT_FRAME && slv_last) begin
            slv_active_q <= 1'b0;
        end
    end

    // completed word to the rx fifo; a full fifo drops it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_push_q <= 1'b0;
            rx_word_q <= '0;
        end else begin
            rx_push_q <= mst_done | slv_last;
            if (mst_done) begin
                rx_word_q <= rxsh_q;
            end else if (slv_last) begin
                rx_word_q <= {rxsh_q[WW-2:0], din};
            end
        end
    end

    // overrun is sticky; a new overrun wins over the clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            overrun_q <= 1'b0;
        end else if (rx_push_q && rx_full) begin
            overrun_q <= 1'b1;
        end else if (overrun_clear) begin
            overrun_q <= 1'b0;
        end
    end

    // level sources at half depth, each with its own mask
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= ((tx_level <= LVL_HALF) & ~mask_tx) |
                     ((rx_level >= LVL_HALF) & ~mask_rx) |
                     (overrun_q & ~mask_ovr);
        end
    end

    // serial clock: toggles per half tick, rests at the target idle level
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sclk_q <= 1'b0;
        end else if (load_go) begin
            sclk_q <= per_target_config_pol[load_tgt] ^ per_target_config_fmt[load_tgt];
        end else if (half_tick_q && (state_q == smsf_pkg::ST_SYNC ||
                                     state_q == smsf_pkg::ST_SHIFT)) begin
            sclk_q <= ~sclk_q;
        end else if (state_q == smsf_pkg::ST_IDLE) begin
            sclk_q <= per_target_config_pol[tgt_q] ^ per_target_config_fmt[tgt_q];
        end
    end

    // select lines: one target at a time in the sequence
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sel_q <= '1;
        end else if (!mst_on || state_q == smsf_pkg::ST_IDLE) begin
            sel_q <= load_go ? (sel_idle ^ (TARGETS'(1) << load_tgt)) : sel_idle;
        end else if (load_go) begin
            sel_q <= sel_idle ^ (TARGETS'(1) << load_tgt);
        end else if (state_q == smsf_pkg::ST_SYNC && half_tick_q && phase_q) begin
            sel_q <= sel_idle;
        end else if (mst_done) begin
            sel_q <= sel_idle;
        end
    end

    // clock and select pins face outward only in master mode
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sclk_oe_n_q <= 1'b1;
            sel_oe_n_q <= 1'b1;
            busy_q <= 1'b0;
        end else begin
            sclk_oe_n_q <= ~mst_on;
            sel_oe_n_q <= ~mst_on;
            busy_q <= (state_q != smsf_pkg::ST_IDLE) | slv_active_q;
        end
    end

    assign combined_irq_out = irq_q;
    assign serial_clock_pin_out = sclk_q;
    assign serial_clock_pin_oe_n = sclk_oe_n_q;
    assign slave_select_line_out = sel_q;
    assign slave_select_line_oe_n = sel_oe_n_q;
    assign serial_data_out_pin = shreg_q[WW-1];
endmodule

// ---- smsf_sva.sv ----
`timescale 1ns/1ps
module smsf_sva #(
    parameter int TARGETS = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic master_mode,
    input wire logic serial_branch_clock,
    input wire logic [TARGETS-1:0] per_target_config_fmt,
    input wire logic mask_tx,
    input wire logic mask_rx,
    input wire logic mask_ovr,
    input wire logic overrun_clear,
    input wire logic rx_empty,
    input wire logic overrun_q,
    input wire logic combined_irq_out,
    input wire logic serial_clock_pin_out,
    input wire logic serial_clock_pin_oe_n,
    input wire logic [TARGETS-1:0] slave_select_line_out,
    input wire logic slave_select_line_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic [7:0] ticks_q;
    // branch ticks since last sclk change
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ticks_q <= 8'h00;
        end else if ($changed(serial_clock_pin_out)) begin
            ticks_q <= {7'h00, serial_branch_clock};
        end else if (ticks_q != 8'hFF) begin
            ticks_q <= ticks_q + {7'h00, serial_branch_clock};
        end
    end

    sequence ovr_live;
        overrun_q && !mask_ovr;
    endsequence
    sequence all_masked;
        mask_tx && mask_rx && mask_ovr;
    endsequence
    // judge selects on settled config
    sequence sel_settled;
        !$past(sys_rst) && $stable(per_target_config_fmt) && !slave_select_line_oe_n;
    endsequence

    chk_ovr_irq: assert property (ovr_live |=> combined_irq_out)
        else $error("overrun unmasked but no irq");
    chk_masked_quiet: assert property (all_masked |=> !combined_irq_out)
        else $error("irq with all masked");
    chk_ovr_sticky: assert property (overrun_q && !overrun_clear |=> overrun_q)
        else $error("overrun lost");
    chk_ovr_full: assert property ($rose(overrun_q) |-> !rx_empty)
        else $error("overrun with rx empty");
    chk_slave_pins: assert property (!master_mode && $past(!master_mode)
        |-> serial_clock_pin_oe_n && slave_select_line_oe_n)
        else $error("pins driven in slave mode");
    chk_sclk_rate: assert property ($changed(serial_clock_pin_out) && !serial_clock_pin_oe_n
        |-> ticks_q != 8'h00)
        else $error("sclk faster than branch tick");
    chk_sel_low: assert property (sel_settled and per_target_config_fmt == '0
        |-> $onehot0(~slave_select_line_out))
        else $error("two selects low");
    chk_sel_high: assert property (sel_settled and per_target_config_fmt == '1
        |-> $onehot0(slave_select_line_out))
        else $error("two syncs high");
endmodule

bind smsf_top smsf_sva #(.TARGETS(TARGETS)) u_sva (
    .clk, .sys_rst, .master_mode, .serial_branch_clock, .per_target_config_fmt,
    .mask_tx, .mask_rx, .mask_ovr, .overrun_clear, .rx_empty, .overrun_q,
    .combined_irq_out, .serial_clock_pin_out, .serial_clock_pin_oe_n,
    .slave_select_line_out, .slave_select_line_oe_n
);

// ---- smsf_peer.sv ----
`timescale 1ns/1ps
module smsf_peer (
    input wire logic sclk,
    input wire logic [3:0] sel_n,
    input wire logic mosi,
    input wire logic [15:0] len_vec,
    output logic miso,
    output logic [15:0] got [8],
    output int frames
);
    localparam logic [15:0] REPLY = 16'hC3A5;
    logic [15:0] shift;
    int idx;
    initial begin
        miso = 1'b0;
        frames = 0;
        idx = -1;
        shift = 16'h0000;
    end
    // new select: target length, reply msb out
    always @(negedge (&sel_n)) begin
        for (int t = 0; t < 4; t++) begin
            if (!sel_n[t]) begin
                idx = int'((len_vec[4*t+:4] < 4'h3) ? 4'h3 : len_vec[4*t+:4]);
            end
        end
        shift = 16'h0000;
        miso = REPLY[idx];
    end
    // leading edge takes a bit
    always @(posedge sclk) begin
        if (!(&sel_n) && idx >= 0 && frames < 8) begin
            shift = {shift[14:0], mosi};
            if (idx == 0) begin
                got[frames] = shift;
                frames++;
                idx = -1;
            end
        end
    end
    // trailing edge: next reply bit
    always @(negedge sclk) begin
        if (!(&sel_n) && idx > 0) begin
            idx--;
            miso = REPLY[idx];
        end
    end
    // released line shows the inverse, no pull
    always @(posedge (&sel_n)) begin
        miso = ~miso;
    end
endmodule

// ---- smsf_tb_top.sv ----
`timescale 1ns/1ps
module smsf_tb_top;
    localparam logic [15:0] REPLY = 16'hC3A5;
    localparam int LIMIT = 20000;
    logic clk, sys_rst, enable, master_mode, loopback, serial_branch_clock;
    logic [7:0] prescale, bit_rate_div;
    logic [1:0] seq_last;
    logic [15:0] per_target_config_len, tx_data, rx_data;
    logic [3:0] per_target_config_fmt, per_target_config_pol, slave_select_line_out;
    logic sw_start, timer_trigger, timer_trig_en, tx_push, rx_pop, overrun_clear;
    logic mask_tx, mask_rx, mask_ovr, serial_clock_pin_in, slave_select_zero_in;
    logic serial_data_in_pin, sdi_q, peer_miso, tx_full, rx_empty, overrun_q, busy_q;
    logic combined_irq_out, serial_clock_pin_out, serial_clock_pin_oe_n;
    logic slave_select_line_oe_n, serial_data_out_pin;
    logic [15:0] peer_got [8];
    logic [15:0] w [4];
    int peer_frames, num_errors = 0, compares = 0, cycles = 0;

    // peer drives data in only in master mode
    assign serial_data_in_pin = master_mode ? peer_miso : sdi_q;

    smsf_top DUT (
        .clk, .sys_rst, .enable, .master_mode, .loopback, .serial_branch_clock, .prescale,
        .bit_rate_div, .seq_last, .per_target_config_len, .per_target_config_fmt,
        .per_target_config_pol, .sw_start, .timer_trigger, .timer_trig_en, .tx_push,
        .tx_data, .rx_pop, .mask_tx, .mask_rx, .mask_ovr, .overrun_clear,
        .serial_clock_pin_in, .slave_select_zero_in, .serial_data_in_pin, .tx_full,
        .rx_empty, .rx_data, .overrun_q, .busy_q, .combined_irq_out, .serial_clock_pin_out,
        .serial_clock_pin_oe_n, .slave_select_line_out, .slave_select_line_oe_n,
        .serial_data_out_pin
    );
    smsf_peer u_peer (
        .sclk(serial_clock_pin_out), .sel_n(slave_select_line_out),
        .mosi(serial_data_out_pin), .len_vec(per_target_config_len), .miso(peer_miso),
        .got(peer_got), .frames(peer_frames)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // branch tick every other cycle; cycle ceiling cuts a hang
    always @(posedge clk) begin
        serial_branch_clock <= sys_rst ? 1'b0 : ~serial_branch_clock;
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            num_errors++;
            end_of_test();
        end
    end

    task end_of_test();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // code below 3 means 4 bits
    function logic [15:0] lmask(input logic [3:0] c);
        return 16'hFFFF >> (4'hF - ((c < 4'h3) ? 4'h3 : c));
    endfunction
    task push(input logic [15:0] d);
        tx_data <= d;
        tx_push <= 1'b1;
        @(posedge clk);
        tx_push <= 1'b0;
        @(posedge clk);
    endtask
    task pop_check(input logic [15:0] m, input logic [15:0] exp);
        check(rx_data & m, exp & m);
        rx_pop <= 1'b1;
        @(posedge clk);
        rx_pop <= 1'b0;
        @(posedge clk);
    endtask
    // start a sequence, wait out busy
    task run(input logic by_timer);
        timer_trigger <= by_timer;
        sw_start <= !by_timer;
        @(posedge clk);
        timer_trigger <= 1'b0;
        sw_start <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 3000 && busy_q !== 1'b0; i++) @(posedge clk);
        repeat (6) @(posedge clk);
    endtask
    // external master at a quarter of the branch rate
    task slave_byte(input logic [7:0] mo, input logic [7:0] mi);
        slave_select_zero_in <= 1'b0;
        repeat (8) @(posedge clk);
        for (int b = 7; b >= 0; b--) begin
            sdi_q <= mo[b];
            repeat (4) @(posedge clk);
            check(16'(serial_data_out_pin), 16'(mi[b]));
            serial_clock_pin_in <= 1'b1;
            repeat (4) @(posedge clk);
            serial_clock_pin_in <= 1'b0;
        end
        repeat (8) @(posedge clk);
        slave_select_zero_in <= 1'b1;
        repeat (8) @(posedge clk);
    endtask

    initial begin
        {sys_rst, enable, master_mode, slave_select_zero_in} = 4'hF;
        {loopback, serial_branch_clock, sw_start, timer_trigger, timer_trig_en} = 5'h00;
        {tx_push, rx_pop, overrun_clear, mask_tx, mask_rx, mask_ovr} = 6'h00;
        {serial_clock_pin_in, sdi_q, seq_last} = 4'h0;
        {prescale, bit_rate_div} = 16'h0001;
        per_target_config_len = 16'hFB73;
        {per_target_config_fmt, per_target_config_pol} = 8'h00;
        tx_data = 16'h0000;
        w = '{16'h9ABC, 16'h5A5A, 16'h0F0F, 16'hBEEF};
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        check(16'(combined_irq_out), 16'h0001);
        // four targets, each its own length
        for (int i = 0; i < 4; i++) push(w[i]);
        seq_last <= 2'h3;
        run(1'b0);
        check(16'(peer_frames), 16'h0004);
        for (int t = 0; t < 4; t++) begin
            check(peer_got[t], w[t] & lmask(per_target_config_len[4*t+:4]));
            pop_check(lmask(per_target_config_len[4*t+:4]), REPLY);
        end
        // trigger ignored until enabled
        seq_last <= 2'h0;
        push(16'h0123);
        run(1'b1);
        check(16'(peer_frames), 16'h0004);
        timer_trig_en <= 1'b1;
        run(1'b1);
        check(16'(peer_frames), 16'h0005);
        timer_trig_en <= 1'b0;
        pop_check(lmask(4'h3), REPLY);
        // loopback frame-pulse, code 0: fill both fifos
        loopback <= 1'b1;
        per_target_config_fmt <= 4'hF;
        per_target_config_len <= 16'hFB70;
        for (int i = 0; i < 33; i++) push(16'h1230 + 16'(i));
        check(16'(tx_full), 16'h0001);
        for (int i = 0; i < 32; i++) run(1'b0);
        check(16'({overrun_q, rx_empty}), 16'h0000);
        {mask_tx, mask_rx, mask_ovr} <= 3'b111;
        push(16'h0007);
        run(1'b0);
        check(16'(overrun_q), 16'h0001);
        check(16'(combined_irq_out), 16'h0000);
        mask_ovr <= 1'b0;
        repeat (3) @(posedge clk);
        check(16'(combined_irq_out), 16'h0001);
        overrun_clear <= 1'b1;
        @(posedge clk);
        overrun_clear <= 1'b0;
        repeat (3) @(posedge clk);
        check(16'(overrun_q), 16'h0000);
        for (int i = 0; i < 32; i++) pop_check(16'h000F, 16'(i));
        check(16'(rx_empty), 16'h0001);
        // slave: one byte each way
        master_mode <= 1'b0;
        loopback <= 1'b0;
        per_target_config_fmt <= 4'h0;
        per_target_config_len <= 16'hFB77;
        push(16'h00A5);
        repeat (8) @(posedge clk);
        slave_byte(8'h3C, 8'hA5);
        pop_check(16'h00FF, 16'h003C);
        end_of_test();
    end
endmodule
